// >>> hdl/custom_pulse_shaper_pkg.sv
`default_nettype none
package custom_pulse_shaper_pkg;

   // Structure of the store and the control port
   localparam int CH_COUNT    = 8;
   localparam int CHAN_W      = 3;
   localparam int PHASE_W     = 5;
   localparam int PHASE_DEPTH = 32;
   localparam int SAMPLE_W    = 7;
   localparam int DATA_W      = 8;
   localparam int REG_ADDR_W  = 5;

   // Register offsets on the control port
   localparam logic [REG_ADDR_W-1:0] OFS_GLOBAL_CONTROL     = 5'h0f;
   localparam logic [REG_ADDR_W-1:0] OFS_LINE_LENGTH_SELECT = 5'h10;
   localparam logic [REG_ADDR_W-1:0] OFS_LINE_LENGTH_DATA   = 5'h11;
   localparam logic [REG_ADDR_W-1:0] OFS_BROADCAST_MASK     = 5'h16;
   localparam logic [REG_ADDR_W-1:0] OFS_SAMPLE_ADDRESS     = 5'h17;
   localparam logic [REG_ADDR_W-1:0] OFS_SAMPLE_DATA        = 5'h18;
   localparam logic [REG_ADDR_W-1:0] OFS_SOURCE_ENABLE      = 5'h19;
   localparam logic [REG_ADDR_W-1:0] OFS_OVF_IRQ_ENABLE     = 5'h1a;
   localparam logic [REG_ADDR_W-1:0] OFS_OVF_IRQ_STATUS     = 5'h1b;

   // Field positions
   localparam int AUTO_INC_BIT  = 7;
   localparam int ADDR_CHAN_LSB = 5;

   // Reset values
   localparam logic [DATA_W-1:0]   REG_RESET    = 8'h00;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 7'h00;

   // Line length codes that pick the sample count
   localparam logic [DATA_W-1:0] LL_CODE_E1    = 8'h00;
   localparam logic [DATA_W-1:0] LL_CODE_T1_26 = 8'h01;

   // Samples per unit interval
   localparam logic [PHASE_W-1:0] UI_LEN_E1      = 5'h0c;
   localparam logic [PHASE_W-1:0] UI_LEN_T1_SHRT = 5'h0d;
   localparam logic [PHASE_W-1:0] UI_LEN_T1_LONG = 5'h0e;

   // Extremes of the seven-bit two's complement sample
   localparam logic [SAMPLE_W-1:0] SAMPLE_MAX_POS = 7'h3f;
   localparam logic [SAMPLE_W-1:0] SAMPLE_MAX_NEG = 7'h40;

   // Pulse length modes
   typedef enum logic [1:0] {
      MODE_E1    = 2'b00,
      MODE_T1_26 = 2'b01,
      MODE_T1_28 = 2'b10
   } pulse_mode_t;

endpackage

`default_nettype wire

// >>> hdl/custom_pulse_shaper.sv
// Contract
// R1: Every one of eight channels owns its own pulse-shape store.
// R2: Pulse spans two intervals; 12 samples each in E1, 13 or 14 in T1.
// R3: In E1 mode second-interval samples are ignored; software writes them zero.
// R4: Software loads the address register, then reads or writes the data window.
// R5: Software keeps away from unused upper sample addresses.
// R6: Samples are seven-bit two's complement, 0x3f highest, 0x40 lowest.
// R7: Samples are inverted automatically for negative-going pulses.
// R8: Lowest sample address is sent first, then ascending addresses.
// R9: Writes to unused locations 28 to 31 are kept but never sent.
// R10: Enable bit one picks the custom shape, zero the built-in shape.
// R11: Sample address is the low five bits, channel the upper bits.
// R12: With auto-increment set, each data access advances the sample address.
// R13: Auto-increment never changes the channel field.
// R14: Software rewrites the address to restart; no automatic wrap at count.
// R15: Broadcast register bit n selects channel n for shared writes.
// R16: Data reads ignore broadcast and read the addressed channel only.
// R17: Data writes hit the addressed channel plus every broadcast channel.
// R18: Software uses the store only while the device is in host mode.
// R19: Mode of 24, 26 or 28 samples set by line length registers.
// R20: Overflow flagged when pairwise interval sums leave the seven-bit range.
// R21: Enabled overflow changes drive the low interrupt; status read clears it.
// R22: Custom-shape enable bits clear to zero at reset.
// R23: Channel field of the address register is three bits, binary coded.
// R24: Configuration registers are eight bits wide and read back as written.
`timescale 1ns/1ps
`default_nettype none

module custom_pulse_shaper (
   // Clock and reset
   input  wire logic                                          i_sys_clk,
   input  wire logic                                          i_reset_n,
   // Control port
   input  wire logic [custom_pulse_shaper_pkg::REG_ADDR_W-1:0] i_reg_addr,
   input  wire logic [custom_pulse_shaper_pkg::DATA_W-1:0]     i_reg_wdata,
   input  wire logic                                          i_reg_wr,
   input  wire logic                                          i_reg_rd,
   output logic      [custom_pulse_shaper_pkg::DATA_W-1:0]     o_reg_rdata,
   output logic                                               o_reg_rvalid,
   // Pulse generator sample port
   input  wire logic [custom_pulse_shaper_pkg::CHAN_W-1:0]     i_tx_channel,
   input  wire logic [custom_pulse_shaper_pkg::PHASE_W-1:0]    i_tx_phase,
   input  wire logic                                          i_tx_negative,
   output logic      [custom_pulse_shaper_pkg::SAMPLE_W-1:0]   o_tx_sample,
   output logic                                               o_tx_custom,
   output custom_pulse_shaper_pkg::pulse_mode_t               o_tx_mode,
   output logic      [custom_pulse_shaper_pkg::CH_COUNT-1:0]   o_source_enable,
   // Interrupt
   output logic                                               o_irq_n
);
   import custom_pulse_shaper_pkg::*;

   // Mode decode from a channel's line length code
   function automatic pulse_mode_t mode_of(input logic [DATA_W-1:0] code);
      pulse_mode_t m;
      case (code)
         LL_CODE_E1:    m = MODE_E1;
         LL_CODE_T1_26: m = MODE_T1_26;
         default:       m = MODE_T1_28;
      endcase
      return m;
   endfunction

   // Samples in one unit interval for a mode
   // R2: interval sample counts
   function automatic logic [PHASE_W-1:0] ui_len(input pulse_mode_t m);
      logic [PHASE_W-1:0] n;
      case (m)
         MODE_E1:    n = UI_LEN_E1;
         MODE_T1_26: n = UI_LEN_T1_SHRT;
         default:    n = UI_LEN_T1_LONG;
      endcase
      return n;
   endfunction

   // True when the sum of two samples leaves the seven-bit range
   function automatic logic sum_overflows(input logic [SAMPLE_W-1:0] a,
                                          input logic [SAMPLE_W-1:0] b);
      logic [SAMPLE_W:0] s;
      s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
      return s[SAMPLE_W] != s[SAMPLE_W-1];
   endfunction

   // Sample store, one bank per channel
   logic [SAMPLE_W-1:0] mem_reg [0:CH_COUNT-1][0:PHASE_DEPTH-1];
   logic [CH_COUNT-1:0] mem_we;

   // Configuration and status state
   logic [DATA_W-1:0]   gctl_reg,    gctl_next;
   logic [DATA_W-1:0]   ll_sel_reg,  ll_sel_next;
   logic [DATA_W-1:0]   ll_data_reg [0:CH_COUNT-1];
   logic [DATA_W-1:0]   ll_data_next [0:CH_COUNT-1];
   logic [DATA_W-1:0]   bcast_reg,   bcast_next;
   logic [DATA_W-1:0]   paddr_reg,   paddr_next;
   logic [DATA_W-1:0]   enable_reg,  enable_next;
   logic [DATA_W-1:0]   irq_en_reg,  irq_en_next;
   logic [DATA_W-1:0]   irq_st_reg,  irq_st_next;
   logic [DATA_W-1:0]   rdata_reg,   rdata_next;
   logic                rvalid_reg,  rvalid_next;
   logic                irq_n_reg,   irq_n_next;

   // Overflow scanner state
   logic [CH_COUNT-1:0] ovf_reg,     ovf_next;
   logic [CHAN_W-1:0]   scan_ch_reg, scan_ch_next;
   logic [PHASE_W-1:0]  scan_k_reg,  scan_k_next;
   logic                scan_f_reg,  scan_f_next;

   // Transmit sample state
   logic [SAMPLE_W-1:0] tx_sample_reg, tx_sample_next;
   logic                tx_custom_reg, tx_custom_next;
   pulse_mode_t         tx_mode_reg,   tx_mode_next;

   // Fields of the address register
   logic [CHAN_W-1:0]   sel_ch;
   logic [PHASE_W-1:0]  sel_ph;
   // R11: address split
   // R23: three-bit channel
   assign sel_ch = paddr_reg[ADDR_CHAN_LSB +: CHAN_W];
   assign sel_ph = paddr_reg[PHASE_W-1:0];

   // Control port decode, register updates and read mux
   always_comb begin
      logic                wr_data;
      logic                data_access;
      logic [CH_COUNT-1:0] ovf_set;
      logic [CHAN_W-1:0]   ll_ch;
      wr_data     = i_reg_wr && (i_reg_addr == OFS_SAMPLE_DATA);
      data_access = (i_reg_wr || i_reg_rd) &&
                    (i_reg_addr == OFS_SAMPLE_DATA);
      ll_ch       = ll_sel_reg[CHAN_W-1:0];
      ovf_set     = '0;
      gctl_next   = gctl_reg;
      ll_sel_next = ll_sel_reg;
      bcast_next  = bcast_reg;
      paddr_next  = paddr_reg;
      enable_next = enable_reg;
      irq_en_next = irq_en_reg;
      for (int c = 0; c < CH_COUNT; c++) begin
         ll_data_next[c] = ll_data_reg[c];
      end
      // R24: plain read/write registers
      if (i_reg_wr) begin
         case (i_reg_addr)
            OFS_GLOBAL_CONTROL:     gctl_next   = i_reg_wdata;
            OFS_LINE_LENGTH_SELECT: ll_sel_next = i_reg_wdata;
            OFS_BROADCAST_MASK:     bcast_next  = i_reg_wdata;
            OFS_SAMPLE_ADDRESS:     paddr_next  = i_reg_wdata;
            OFS_SOURCE_ENABLE:      enable_next = i_reg_wdata;
            OFS_OVF_IRQ_ENABLE:     irq_en_next = i_reg_wdata;
            // R19: mode per channel
            OFS_LINE_LENGTH_DATA:   ll_data_next[ll_ch] = i_reg_wdata;
            default:                gctl_next   = gctl_reg;
         endcase
      end
      // R12: auto-increment on data access
      // R13: channel field kept
      // R14: plain five-bit count, no mode wrap
      if (data_access && gctl_reg[AUTO_INC_BIT]) begin
         paddr_next = {paddr_reg[DATA_W-1:PHASE_W],
                       PHASE_W'(sel_ph + 5'h01)};
      end
      // R15: broadcast mask
      // R17: addressed channel always written
      mem_we = '0;
      if (wr_data) begin
         mem_we = bcast_reg | (CH_COUNT'(1) << sel_ch);
      end
      // Read mux; the answer is registered one cycle later
      rdata_next  = rdata_reg;
      rvalid_next = i_reg_rd;
      if (i_reg_rd) begin
         case (i_reg_addr)
            OFS_GLOBAL_CONTROL:     rdata_next = gctl_reg;
            OFS_LINE_LENGTH_SELECT: rdata_next = ll_sel_reg;
            OFS_LINE_LENGTH_DATA:   rdata_next = ll_data_reg[ll_ch];
            OFS_BROADCAST_MASK:     rdata_next = bcast_reg;
            OFS_SAMPLE_ADDRESS:     rdata_next = paddr_reg;
            // R16: reads ignore broadcast
            OFS_SAMPLE_DATA:        rdata_next = {1'b0,
                                                  mem_reg[sel_ch][sel_ph]};
            OFS_SOURCE_ENABLE:      rdata_next = enable_reg;
            OFS_OVF_IRQ_ENABLE:     rdata_next = irq_en_reg;
            OFS_OVF_IRQ_STATUS:     rdata_next = irq_st_reg;
            default:                rdata_next = REG_RESET;
         endcase
      end
      // Overflow scanner: one sample pair per cycle, one channel at a time
      scan_f_next  = scan_f_reg;
      scan_k_next  = scan_k_reg;
      scan_ch_next = scan_ch_reg;
      ovf_next     = ovf_reg;
      begin
         logic [PHASE_W-1:0] n;
         logic               bad;
         n   = ui_len(mode_of(ll_data_reg[scan_ch_reg]));
         // R20: pairwise interval sum check
         bad = sum_overflows(mem_reg[scan_ch_reg][scan_k_reg],
                    mem_reg[scan_ch_reg][PHASE_W'(scan_k_reg + n)]);
         if (scan_k_reg == PHASE_W'(n - 5'h01)) begin
            ovf_next[scan_ch_reg] = scan_f_reg | bad;
            scan_f_next  = 1'b0;
            scan_k_next  = '0;
            scan_ch_next = CHAN_W'(scan_ch_reg + 3'h1);
         end else begin
            scan_f_next  = scan_f_reg | bad;
            scan_k_next  = PHASE_W'(scan_k_reg + 5'h01);
         end
         ovf_set = (ovf_next ^ ovf_reg) & irq_en_reg;
      end
      // R21: status read clears; a new change in the same cycle wins
      irq_st_next = irq_st_reg;
      if (i_reg_rd && (i_reg_addr == OFS_OVF_IRQ_STATUS)) begin
         irq_st_next = REG_RESET;
      end
      irq_st_next = irq_st_next | ovf_set;
      irq_n_next  = ~(|irq_st_next);
   end

   // Transmit sample selection for the pulse generator
   always_comb begin
      pulse_mode_t         m;
      logic [PHASE_W-1:0]  lim;
      logic [SAMPLE_W-1:0] raw;
      m   = mode_of(ll_data_reg[i_tx_channel]);
      lim = PHASE_W'(ui_len(m) + ui_len(m));
      // R8: phase index is time order
      raw = mem_reg[i_tx_channel][i_tx_phase];
      // R3: E1 sends only the first interval
      if (m == MODE_E1) begin
         lim = ui_len(m);
      end
      // R9: locations past the mode's count are never sent
      if (i_tx_phase >= lim) begin
         raw = SAMPLE_RESET;
      end
      // R7: inversion; the most negative code saturates on negation
      // R6: seven-bit two's complement arithmetic
      if (i_tx_negative) begin
         if (raw == SAMPLE_MAX_NEG) begin
            raw = SAMPLE_MAX_POS;
         end else begin
            raw = SAMPLE_W'(~raw + 7'h01);
         end
      end
      tx_sample_next = raw;
      // R10: source select per channel
      tx_custom_next = enable_reg[i_tx_channel];
      tx_mode_next   = m;
   end

   // Sample banks; store contents cleared so overflow starts defined
   genvar g;
   generate
      for (g = 0; g < CH_COUNT; g++) begin : g_bank
         // R1: independent bank per channel
         always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               for (int p = 0; p < PHASE_DEPTH; p++) begin
                  mem_reg[g][p] <= SAMPLE_RESET;
               end
            end else if (mem_we[g]) begin
               mem_reg[g][sel_ph] <= i_reg_wdata[SAMPLE_W-1:0];
            end
         end
      end
   endgenerate

   // State registers
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gctl_reg      <= REG_RESET;
         ll_sel_reg    <= REG_RESET;
         bcast_reg     <= REG_RESET;
         paddr_reg     <= REG_RESET;
         // R22: built-in shapes after reset
         enable_reg    <= REG_RESET;
         irq_en_reg    <= REG_RESET;
         irq_st_reg    <= REG_RESET;
         rdata_reg     <= REG_RESET;
         rvalid_reg    <= 1'b0;
         irq_n_reg     <= 1'b1;
         ovf_reg       <= '0;
         scan_ch_reg   <= '0;
         scan_k_reg    <= '0;
         scan_f_reg    <= 1'b0;
         tx_sample_reg <= SAMPLE_RESET;
         tx_custom_reg <= 1'b0;
         tx_mode_reg   <= MODE_E1;
         for (int c = 0; c < CH_COUNT; c++) begin
            ll_data_reg[c] <= REG_RESET;
         end
      end else begin
         gctl_reg      <= gctl_next;
         ll_sel_reg    <= ll_sel_next;
         bcast_reg     <= bcast_next;
         paddr_reg     <= paddr_next;
         enable_reg    <= enable_next;
         irq_en_reg    <= irq_en_next;
         irq_st_reg    <= irq_st_next;
         rdata_reg     <= rdata_next;
         rvalid_reg    <= rvalid_next;
         irq_n_reg     <= irq_n_next;
         ovf_reg       <= ovf_next;
         scan_ch_reg   <= scan_ch_next;
         scan_k_reg    <= scan_k_next;
         scan_f_reg    <= scan_f_next;
         tx_sample_reg <= tx_sample_next;
         tx_custom_reg <= tx_custom_next;
         tx_mode_reg   <= tx_mode_next;
         for (int c = 0; c < CH_COUNT; c++) begin
            ll_data_reg[c] <= ll_data_next[c];
         end
      end
   end

   // Outputs straight from flip-flops
   assign o_reg_rdata     = rdata_reg;
   assign o_reg_rvalid    = rvalid_reg;
   assign o_tx_sample     = tx_sample_reg;
   assign o_tx_custom     = tx_custom_reg;
   assign o_tx_mode       = tx_mode_reg;
   assign o_source_enable = enable_reg;
   assign o_irq_n         = irq_n_reg;

endmodule

`default_nettype wire

// >>> tb/custom_pulse_shaper_checker.sv
`timescale 1ns/1ps
`default_nettype none
module custom_pulse_shaper_checker
   import custom_pulse_shaper_pkg::*;
(
   // Clock and reset
   input wire logic                  i_sys_clk,
   input wire logic                  i_reset_n,
   // Control port
   input wire logic [REG_ADDR_W-1:0] i_reg_addr,
   input wire logic                  i_reg_rd,
   input wire logic [DATA_W-1:0]     o_reg_rdata,
   input wire logic                  o_reg_rvalid,
   // Pulse generator side
   input wire logic [CHAN_W-1:0]     i_tx_channel,
   input wire logic [PHASE_W-1:0]    i_tx_phase,
   input wire logic                  i_tx_negative,
   input wire logic [SAMPLE_W-1:0]   o_tx_sample,
   input wire logic                  o_tx_custom,
   input wire pulse_mode_t           o_tx_mode,
   input wire logic [CH_COUNT-1:0]   o_source_enable,
   input wire logic                  o_irq_n
);
   // Enable bit of the channel asked for, one cycle late like the port
   logic sel_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= o_source_enable[i_tx_channel];
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   // Status read, the step that must release the interrupt
   sequence s_stat_rd;
      i_reg_rd && i_reg_addr == OFS_OVF_IRQ_STATUS;
   endsequence

   property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read answer missing");
   property p_no_rvalid; !i_reg_rd |=> !o_reg_rvalid; endproperty
   a_no_rvalid: assert property (p_no_rvalid)
      else $error("read answer without read");
   property p_hold; !o_reg_rvalid |-> $stable(o_reg_rdata); endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved between reads");
   // Guarded by a quiet enable register so a write cannot race the port
   property p_custom;
      $stable(o_source_enable) |-> o_tx_custom == sel_q;
   endproperty
   a_custom: assert property (p_custom)
      else $error("custom flag does not follow enable bit");
   property p_e1_tail;
      o_tx_mode == MODE_E1 && $past(i_tx_phase) >= UI_LEN_E1
         |-> o_tx_sample == SAMPLE_RESET;
   endproperty
   a_e1_tail: assert property (p_e1_tail)
      else $error("tail sample sent in E1 mode");
   property p_t26_tail;
      o_tx_mode == MODE_T1_26 && $past(i_tx_phase) >= 2 * UI_LEN_T1_SHRT
         |-> o_tx_sample == SAMPLE_RESET;
   endproperty
   a_t26_tail: assert property (p_t26_tail)
      else $error("unused location sent in short T1 mode");
   property p_neg_sat;
      $past(i_tx_negative) |-> o_tx_sample != SAMPLE_MAX_NEG;
   endproperty
   a_neg_sat: assert property (p_neg_sat)
      else $error("inverted sample out of range");
   property p_irq_clear; s_stat_rd |=> ##1 o_irq_n; endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt not released by status read");
   property p_irq_rise;
      $rose(o_irq_n) |-> $past(i_reg_rd) &&
         $past(i_reg_addr) == OFS_OVF_IRQ_STATUS;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt released without status read");
endmodule
`default_nettype wire

// >>> tb/shaper_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shaper_host_model
   import custom_pulse_shaper_pkg::*;
(
   // Clock
   input wire logic                   i_sys_clk,
   // Control port, host side
   output logic [REG_ADDR_W-1:0]      o_reg_addr,
   output logic [DATA_W-1:0]          o_reg_wdata,
   output logic                       o_reg_wr,
   output logic                       o_reg_rd,
   input  wire logic [DATA_W-1:0]     i_reg_rdata,
   input  wire logic                  i_reg_rvalid
);
   // Idle bus at time zero
   initial begin
      o_reg_addr = 5'h00;
      o_reg_wdata = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
   end

   // One-cycle write strobe; data line then shows the inverse, not a copy
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_addr <= a;
      o_reg_wdata <= d;
      o_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_wr <= 1'b0;
      o_reg_wdata <= ~d;
   endtask

   // One-cycle read strobe, answer taken at the edge that shows it
   task automatic rd(input logic [4:0] a, output logic [7:0] d,
                     output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge i_sys_clk);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge i_sys_clk);
         if (i_reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = i_reg_rdata;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/custom_pulse_shaper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module custom_pulse_shaper_tb;
   import custom_pulse_shaper_pkg::*;
   // Nets named after the ports they meet
   logic                  i_sys_clk = 1'b0;
   logic                  i_reset_n = 1'b0;
   logic [REG_ADDR_W-1:0] i_reg_addr;
   logic [DATA_W-1:0]     i_reg_wdata, o_reg_rdata;
   logic                  i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic [CHAN_W-1:0]     i_tx_channel = 3'h0;
   logic [PHASE_W-1:0]    i_tx_phase = 5'h00;
   logic                  i_tx_negative = 1'b0;
   logic [SAMPLE_W-1:0]   o_tx_sample;
   logic                  o_tx_custom, o_irq_n;
   pulse_mode_t           o_tx_mode;
   logic [CH_COUNT-1:0]   o_source_enable;
   int                    miscompares = 0;
   int                    n_compared = 0;
   logic [4:0]            ofs [7] = '{5'h0f, 5'h10, 5'h11, 5'h16, 5'h17,
                                      5'h19, 5'h1a};

   always #2 i_sys_clk = ~i_sys_clk;

   custom_pulse_shaper dut (.i_sys_clk, .i_reset_n, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
      .i_tx_channel, .i_tx_phase, .i_tx_negative, .o_tx_sample,
      .o_tx_custom, .o_tx_mode, .o_source_enable, .o_irq_n);
   shaper_host_model h (.i_sys_clk, .o_reg_addr(i_reg_addr),
      .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
      .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid));

   // Verdict and end of run
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register read; a missing answer ends the run
   task automatic rr(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      h.rd(a, d, ok);
      if (!ok) begin
         miscompares++;
         conclude();
      end else begin
         chk(d, exp);
      end
   endtask

   // One pulse generator request, answer one cycle later
   task automatic tx(input logic [2:0] c, input logic [4:0] p,
                     input logic n, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_tx_channel <= c;
      i_tx_phase <= p;
      i_tx_negative <= n;
      @(posedge i_sys_clk);
      #1 chk(o_tx_sample, e);
   endtask

   // Stored pattern of channel 3: ramp, with the most negative code at 1
   function automatic logic [7:0] ex(int k);
      return (k == 1) ? 8'h40 : 8'(k);
   endfunction

   task automatic t_regs();
      rr(OFS_SOURCE_ENABLE, 8'h00);
      chk(o_source_enable, 8'h00);
      foreach (ofs[i]) begin
         h.wr(ofs[i], 8'ha5);
         rr(ofs[i], 8'ha5);
         if (ofs[i] == OFS_SOURCE_ENABLE) chk(o_source_enable, 8'ha5);
         h.wr(ofs[i], 8'h00);
      end
      h.wr(5'h1c, 8'hff);
      rr(5'h1c, 8'h00);
   endtask

   // Host-mode sequence: address first, then data window
   task automatic t_store();
      h.wr(OFS_GLOBAL_CONTROL, 8'h80);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h60);
      for (int k = 0; k < 24; k++) h.wr(OFS_SAMPLE_DATA, 8'(k));
      rr(OFS_SAMPLE_ADDRESS, 8'h78);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h61);
      h.wr(OFS_SAMPLE_DATA, 8'h40);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h60);
      for (int k = 0; k < 24; k++) rr(OFS_SAMPLE_DATA, ex(k));
      h.wr(OFS_SOURCE_ENABLE, 8'h08);
      for (int k = 0; k < 12; k++) tx(3'h3, 5'(k), 1'b0, ex(k));
      chk(o_tx_custom, 8'h01);
      tx(3'h3, 5'h01, 1'b1, 8'h3f);
      tx(3'h3, 5'h02, 1'b1, 8'h7e);
      tx(3'h3, 5'h0c, 1'b0, 8'h00);
      tx(3'h2, 5'h02, 1'b0, 8'h00);
      chk(o_tx_custom, 8'h00);
   endtask

   task automatic t_bcast();
      h.wr(OFS_GLOBAL_CONTROL, 8'h00);
      h.wr(OFS_BROADCAST_MASK, 8'h05);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h25);
      h.wr(OFS_SAMPLE_DATA, 8'h2a);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h05);
      rr(OFS_SAMPLE_DATA, 8'h2a);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h45);
      rr(OFS_SAMPLE_DATA, 8'h2a);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h25);
      rr(OFS_SAMPLE_DATA, 8'h2a);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h85);
      rr(OFS_SAMPLE_DATA, 8'h00);
      h.wr(OFS_BROADCAST_MASK, 8'h00);
   endtask

   task automatic t_mode();
      h.wr(OFS_LINE_LENGTH_SELECT, 8'h03);
      h.wr(OFS_LINE_LENGTH_DATA, LL_CODE_T1_26);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h7a);
      h.wr(OFS_SAMPLE_DATA, 8'h11);
      tx(3'h3, 5'h1a, 1'b0, 8'h00);
      chk(o_tx_mode, MODE_T1_26);
      tx(3'h3, 5'h0d, 1'b0, 8'h0d);
      h.wr(OFS_LINE_LENGTH_DATA, 8'h02);
      tx(3'h3, 5'h1a, 1'b0, 8'h11);
      chk(o_tx_mode, MODE_T1_28);
      h.wr(OFS_LINE_LENGTH_DATA, LL_CODE_E1);
      tx(3'h3, 5'h0d, 1'b0, 8'h00);
   endtask

   task automatic t_ovf();
      h.wr(OFS_OVF_IRQ_ENABLE, 8'h08);
      h.wr(OFS_SAMPLE_ADDRESS, 8'h60);
      h.wr(OFS_SAMPLE_DATA, 8'h3f);
      for (int i = 0; i < 300 && o_irq_n !== 1'b0; i++) @(posedge i_sys_clk);
      chk(o_irq_n, 8'h00);
      // A wait that ran out goes straight to the report
      if (o_irq_n !== 1'b0) begin
         conclude();
      end else begin
         rr(OFS_OVF_IRQ_STATUS, 8'h08);
         repeat (3) @(posedge i_sys_clk);
         chk(o_irq_n, 8'h01);
         h.wr(OFS_OVF_IRQ_ENABLE, 8'h00);
         h.wr(OFS_SAMPLE_DATA, 8'h00);
         repeat (200) @(posedge i_sys_clk);
         chk(o_irq_n, 8'h01);
         rr(OFS_OVF_IRQ_STATUS, 8'h00);
      end
   endtask

   // Reset for ten cycles, then every scenario in turn
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      t_regs();
      t_store();
      t_bcast();
      t_mode();
      t_ovf();
      conclude();
   end
endmodule

bind custom_pulse_shaper custom_pulse_shaper_checker u_chk (.i_sys_clk,
   .i_reset_n, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
   .i_tx_channel, .i_tx_phase, .i_tx_negative, .o_tx_sample, .o_tx_custom,
   .o_tx_mode, .o_source_enable, .o_irq_n);
`default_nettype wire
